// >>> src/utcf_top.v
// Purpose: UART FIFO trigger level selection, trigger interrupts and character format
// Assumes: FIFO counts and the serial engines live outside and are synchronous to pclk
// Notes:   Registers on APB; one level interrupt from sticky status bits
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "utcf_regs.vh"

module utcf_top #(
  parameter CW = 7
) (
  // Clock and reset
  input  wire          pclk,
  input  wire          presetn,
  // APB slave
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [11:0]   paddr,
  input  wire [31:0]   pwdata,
  input  wire [3:0]    pstrb,
  output reg  [31:0]   prdata,
  output reg           pready,
  output reg           pslverr,
  // FIFO occupancy from the datapath
  input  wire [CW-1:0] tx_count,
  input  wire [CW-1:0] rx_count,
  // Received character check
  input  wire          rx_char_valid,
  input  wire [7:0]    rx_char_data,
  input  wire          rx_char_parity,
  // Character format, FIFO enable, trigger level and parity error outputs
  output reg  [3:0]    word_bits,
  output reg  [1:0]    stop_halves,
  output reg           parity_on,
  output reg           tx_parity_bit,
  output reg           fifo_enable,
  output reg  [6:0]    tx_trigger,
  output reg  [6:0]    rx_trigger,
  output reg           parity_error,
  // Interrupt
  output reg           irq
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg  [7:0]    fifo_control;
  reg  [7:0]    line_control;
  reg  [7:0]    feature_control;
  reg  [7:0]    enhanced_function_reg;
  reg  [6:0]    trg_rx;
  reg  [6:0]    trg_tx;
  reg  [2:0]    irq_status;
  reg  [2:0]    irq_mask;
  reg  [CW-1:0] tx_count_d;
  reg  [CW-1:0] rx_count_d;
  reg           tx_filled_over;

  wire       acc   = psel & penable;
  // A write lands only at the edge where pready is seen high, so W1C is applied once
  wire       wr    = acc & pready & pwrite & pstrb[0];
  wire [7:0] wbyte = pwdata[7:0];

  // ----------------------------------------
  // Trigger level decode
  // ----------------------------------------
  reg [6:0] next_tx_trig;
  reg [6:0] next_rx_trig;
  always @* begin
    next_tx_trig = 7'h01;
    next_rx_trig = 7'h01;
    // One table field drives both directions
    case (feature_control[`UTCF_FT_TABLE_LO+1:`UTCF_FT_TABLE_LO])
      2'b00: begin
        next_tx_trig = 7'h01;
        case (fifo_control[`UTCF_FC_RXSEL_LO+1:`UTCF_FC_RXSEL_LO])
          2'b00:   next_rx_trig = 7'h01;
          2'b01:   next_rx_trig = 7'h04;
          2'b10:   next_rx_trig = 7'h08;
          default: next_rx_trig = 7'h0e;
        endcase
      end
      2'b01: begin
        case (fifo_control[`UTCF_FC_TXSEL_LO+1:`UTCF_FC_TXSEL_LO])
          2'b00:   next_tx_trig = 7'h10;
          2'b01:   next_tx_trig = 7'h08;
          2'b10:   next_tx_trig = 7'h18;
          default: next_tx_trig = 7'h1e;
        endcase
        case (fifo_control[`UTCF_FC_RXSEL_LO+1:`UTCF_FC_RXSEL_LO])
          2'b00:   next_rx_trig = 7'h08;
          2'b01:   next_rx_trig = 7'h10;
          2'b10:   next_rx_trig = 7'h18;
          default: next_rx_trig = 7'h1c;
        endcase
      end
      2'b10: begin
        case (fifo_control[`UTCF_FC_TXSEL_LO+1:`UTCF_FC_TXSEL_LO])
          2'b00:   next_tx_trig = 7'h08;
          2'b01:   next_tx_trig = 7'h10;
          2'b10:   next_tx_trig = 7'h20;
          default: next_tx_trig = 7'h38;
        endcase
        case (fifo_control[`UTCF_FC_RXSEL_LO+1:`UTCF_FC_RXSEL_LO])
          2'b00:   next_rx_trig = 7'h08;
          2'b01:   next_rx_trig = 7'h10;
          2'b10:   next_rx_trig = 7'h38;
          default: next_rx_trig = 7'h3c;
        endcase
      end
      default: begin
        next_tx_trig = trg_tx;
        next_rx_trig = trg_rx;
      end
    endcase
  end

  // ----------------------------------------
  // Character format
  // ----------------------------------------
  reg [7:0] char_mask;
  reg       rx_expect;
  always @* begin
    case (line_control[1:0])
      2'b00:   char_mask = 8'h1f;
      2'b01:   char_mask = 8'h3f;
      2'b10:   char_mask = 8'h7f;
      default: char_mask = 8'hff;
    endcase
    if (line_control[`UTCF_LC_FORCE])
      rx_expect = ~line_control[`UTCF_LC_EVEN];
    else
      rx_expect = ~(^(rx_char_data & char_mask) ^ line_control[`UTCF_LC_EVEN]);
  end

  // Events from count history and the received character; levels are cut to CW bits, so a CW below 7 truncates the compare
  wire [CW-1:0] tx_lvl = tx_trigger[CW-1:0];
  wire [CW-1:0] rx_lvl = rx_trigger[CW-1:0];
  wire tx_below = (tx_count < tx_lvl) && (tx_count_d >= tx_lvl);
  wire tx_empty = (tx_count == {CW{1'b0}}) && (tx_count_d != {CW{1'b0}}) && !tx_filled_over;
  wire rx_cross = (rx_count >= rx_lvl) && (rx_count_d < rx_lvl);
  wire perr_ev  = rx_char_valid && line_control[`UTCF_LC_PEN] && (rx_char_parity != rx_expect);
  wire [2:0] ev = {perr_ev, rx_cross, tx_below | tx_empty};

  // ----------------------------------------
  // Register writes and state
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_control          <= `UTCF_RST_BYTE;
      line_control          <= `UTCF_RST_BYTE;
      feature_control       <= `UTCF_RST_BYTE;
      enhanced_function_reg <= `UTCF_RST_BYTE;
      trg_rx                <= `UTCF_RST_TRIG;
      trg_tx                <= `UTCF_RST_TRIG;
      irq_status            <= `UTCF_RST_IRQ;
      irq_mask              <= `UTCF_RST_IRQ;
      tx_count_d            <= {CW{1'b0}};
      rx_count_d            <= {CW{1'b0}};
      tx_filled_over        <= 1'b0;
    end else begin
      tx_count_d <= tx_count;
      rx_count_d <= rx_count;
      // Remember whether the last reload climbed above the level
      if (tx_count == {CW{1'b0}})
        tx_filled_over <= 1'b0;
      else if (tx_count > tx_lvl)
        tx_filled_over <= 1'b1;
      if (wr && paddr == `UTCF_OFF_FIFO_CONTROL && wbyte[`UTCF_FC_ENABLE]) begin
        fifo_control[3:0] <= wbyte[3:0];
        fifo_control[7:6] <= wbyte[7:6];
        if (enhanced_function_reg[`UTCF_EF_ENH])
          fifo_control[5:4] <= wbyte[5:4];
      end else if (wr && paddr == `UTCF_OFF_FIFO_CONTROL)
        fifo_control[`UTCF_FC_ENABLE] <= 1'b0;
      if (wr && paddr == `UTCF_OFF_LINE_CONTROL)
        line_control <= wbyte;
      if (wr && paddr == `UTCF_OFF_FEATURE_CONTROL)
        feature_control <= wbyte;
      if (wr && paddr == `UTCF_OFF_ENHANCED_FUNC)
        enhanced_function_reg <= wbyte;
      if (wr && paddr == `UTCF_OFF_TRIGGER_LEVEL) begin
        if (feature_control[`UTCF_FT_SIDE])
          trg_tx <= wbyte[6:0];
        else
          trg_rx <= wbyte[6:0];
      end
      if (wr && paddr == `UTCF_OFF_IRQ_MASK)
        irq_mask <= wbyte[2:0];
      // Set wins over write-one-to-clear so no event is lost
      if (wr && paddr == `UTCF_OFF_IRQ_STATUS)
        irq_status <= (irq_status & ~wbyte[2:0]) | ev;
      else
        irq_status <= irq_status | ev;
    end
  end

  // ----------------------------------------
  // APB read and registered outputs
  // ----------------------------------------
  reg [7:0] rd_byte;
  reg       rd_hit;
  always @* begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    case (paddr)
      `UTCF_OFF_FIFO_CONTROL:    rd_byte = 8'h00;
      `UTCF_OFF_LINE_CONTROL:    rd_byte = line_control;
      `UTCF_OFF_FEATURE_CONTROL: rd_byte = feature_control;
      `UTCF_OFF_ENHANCED_FUNC:   rd_byte = enhanced_function_reg;
      `UTCF_OFF_TRIGGER_LEVEL:   rd_byte = {1'b0, feature_control[`UTCF_FT_SIDE] ? trg_tx : trg_rx};
      `UTCF_OFF_IRQ_STATUS:      rd_byte = {5'h00, irq_status};
      `UTCF_OFF_IRQ_MASK:        rd_byte = {5'h00, irq_mask};
      `UTCF_OFF_LEVELS:          rd_byte = {1'b0, rx_trigger};
      `UTCF_OFF_TX_COUNT:        rd_byte = {{(8-CW){1'b0}}, tx_count};
      `UTCF_OFF_RX_COUNT:        rd_byte = {{(8-CW){1'b0}}, rx_count};
      default:                   rd_hit  = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata        <= 32'h00000000;
      pready        <= 1'b0;
      pslverr       <= 1'b0;
      word_bits     <= 4'h5;
      stop_halves   <= 2'h2;
      parity_on     <= 1'b0;
      tx_parity_bit <= 1'b0;
      fifo_enable   <= 1'b0;
      tx_trigger    <= `UTCF_RST_TRIG;
      rx_trigger    <= `UTCF_RST_TRIG;
      parity_error  <= 1'b0;
      irq           <= 1'b0;
    end else begin
      // One wait state: answer in the cycle after the access phase opens
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~rd_hit;
      prdata  <= (psel & ~pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
      word_bits   <= {2'b00, line_control[1:0]} + 4'h5;
      if (!line_control[`UTCF_LC_STOP])
        stop_halves <= 2'h2;
      else if (line_control[1:0] == 2'b00)
        stop_halves <= 2'h3;
      else
        stop_halves <= 2'h0;
      parity_on   <= line_control[`UTCF_LC_PEN];
      // Forced value only; unforced parity is computed by the transmit engine
      tx_parity_bit <= ~line_control[`UTCF_LC_EVEN];
      fifo_enable <= fifo_control[`UTCF_FC_ENABLE];
      tx_trigger  <= next_tx_trig;
      rx_trigger  <= next_rx_trig;
      parity_error <= perr_ev;
      irq <= |(irq_status & irq_mask);
    end
  end

endmodule // utcf_top
`default_nettype wire

// >>> include/utcf_regs.vh
// Purpose: Register map and constants for the UART trigger and character format block
// Assumes: APB, 32-bit data, one register per aligned word
// Notes:   Low byte carries data, upper bits read as zero
`ifndef UTCF_REGS_VH
`define UTCF_REGS_VH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define UTCF_OFF_FIFO_CONTROL     12'h000
`define UTCF_OFF_LINE_CONTROL     12'h004
`define UTCF_OFF_FEATURE_CONTROL  12'h008
`define UTCF_OFF_ENHANCED_FUNC    12'h00c
`define UTCF_OFF_TRIGGER_LEVEL    12'h010
`define UTCF_OFF_IRQ_STATUS       12'h014
`define UTCF_OFF_IRQ_MASK         12'h018
`define UTCF_OFF_LEVELS           12'h01c
`define UTCF_OFF_TX_COUNT         12'h020
`define UTCF_OFF_RX_COUNT         12'h024

// ----------------------------------------
// Fields
// ----------------------------------------
`define UTCF_FC_ENABLE    0
`define UTCF_FC_TXSEL_LO  4
`define UTCF_FC_RXSEL_LO  6
`define UTCF_FT_TABLE_LO  4
`define UTCF_FT_SIDE      7
`define UTCF_EF_ENH       4
`define UTCF_LC_STOP      2
`define UTCF_LC_PEN       3
`define UTCF_LC_EVEN      4
`define UTCF_LC_FORCE     5
`define UTCF_IRQ_TX       0
`define UTCF_IRQ_RX       1
`define UTCF_IRQ_PERR     2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define UTCF_RST_BYTE     8'h00
`define UTCF_RST_IRQ      3'h0
`define UTCF_RST_TRIG     7'h01

`endif

// >>> test/utcf_props.sv
// Purpose: Port checks for the trigger and format block
// Assumes: One pclk domain, async active-low reset
// Notes:   Bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module utcf_props #(
  parameter CW = 7
) (
  // Clock and bus
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic       pready,
  input wire logic       pslverr,
  // Format and triggers
  input wire logic       rx_char_valid,
  input wire logic [3:0] word_bits,
  input wire logic [1:0] stop_halves,
  input wire logic       parity_on,
  input wire logic       parity_error,
  input wire logic [6:0] tx_trigger,
  input wire logic [6:0] rx_trigger
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access; psel && penable && !pready; endsequence
  // Format and trigger outputs move only after a write: catches a register that drifts on its own
  a_ready_follows: assert property (s_access |=> pready)
    else $error("no ready after access");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_word_range: assert property (word_bits >= 4'h5 && word_bits <= 4'h8)
    else $error("word length out of range");
  a_stop_length: assert property ((word_bits == 4'h5) ? stop_halves != 2'h0 : stop_halves != 2'h3)
    else $error("stop length wrong for word");
  a_fmt_by_write: assert property ($changed(word_bits) || $changed(parity_on) |-> $past(psel && pwrite) || $past(psel && pwrite, 2))
    else $error("format moved without write");
  a_trig_by_write: assert property ($changed(rx_trigger) || $changed(tx_trigger) |-> $past(psel && pwrite) || $past(psel && pwrite, 2))
    else $error("trigger moved without write");
  a_perr_cause: assert property (parity_error |-> $past(rx_char_valid) && $past(parity_on))
    else $error("parity error without cause");
  a_no_parity: assert property (rx_char_valid && !parity_on |=> !parity_error)
    else $error("parity checked while off");
endmodule // utcf_props
`default_nettype wire

// >>> test/utcf_far_end.sv
// Purpose: FIFO datapath stand-in: occupancy levels and received characters
// Assumes: Synchronous to pclk
// Notes:   Character lines are scrambled once the strobe drops
`timescale 1ns/1ps
`default_nettype none
module utcf_far_end (
  // Clock
  input wire logic       pclk,
  // Datapath
  output var logic [6:0] tx_count,
  output var logic [6:0] rx_count,
  output var logic       rx_char_valid,
  output var logic [7:0] rx_char_data,
  output var logic       rx_char_parity
);
  // ----
  // Drivers
  // ----
  initial begin
    tx_count = 7'h00;
    rx_count = 7'h00;
    rx_char_valid = 1'b0;
    rx_char_data = 8'h00;
    rx_char_parity = 1'b0;
  end
  task automatic set_counts(input logic [6:0] t, input logic [6:0] r);
    @(posedge pclk);
    tx_count <= t;
    rx_count <= r;
    repeat (3) @(posedge pclk);
  endtask
  // Stale data would hide a design that samples late
  task automatic send_char(input logic [7:0] d, input logic p);
    @(posedge pclk);
    rx_char_valid <= 1'b1;
    rx_char_data <= d;
    rx_char_parity <= p;
    @(posedge pclk);
    rx_char_valid <= 1'b0;
    rx_char_data <= ~d;
    rx_char_parity <= ~p;
    repeat (3) @(posedge pclk);
  endtask
endmodule // utcf_far_end
`default_nettype wire

// >>> test/uart_trigger_and_char_format_tb.sv
// Purpose: Self-checking bench for the trigger and format block
// Assumes: APB master tasks, far-end model for counts and characters
// Notes:   Levels held by the model, one scenario per task
`timescale 1ns/1ps
`default_nettype none
`include "utcf_regs.vh"
module uart_trigger_and_char_format_tb;
  // ----
  // Signals
  // ----
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf, word_bits;
  logic pready, pslverr, err, rx_char_valid, rx_char_parity, parity_on, tx_parity_bit, fifo_enable, parity_error, irq;
  logic [6:0] tx_count, rx_count, tx_trigger, rx_trigger;
  logic [7:0] rx_char_data;
  logic [1:0] stop_halves;
  logic [6:0] rxl [12] = '{7'h01, 7'h04, 7'h08, 7'h0e, 7'h08, 7'h10, 7'h18, 7'h1c, 7'h08, 7'h10, 7'h38, 7'h3c};
  logic [6:0] txl [12] = '{7'h01, 7'h01, 7'h01, 7'h01, 7'h10, 7'h08, 7'h18, 7'h1e, 7'h08, 7'h10, 7'h20, 7'h38};
  int n_mismatch = 0, n_checks = 0;
  always #4 pclk = ~pclk;
  utcf_top #(.CW(7)) dut_u (.*);
  utcf_far_end far_u (.*);
  // ----
  // Tasks
  // ----
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_mismatch++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic t_format();
    for (int i = 0; i < 4; i++) begin
      apb(1, `UTCF_OFF_LINE_CONTROL, 32'h4 | i);
      chk("word_bits", word_bits, 4'h5 + i);
      chk("stop_halves", stop_halves, (i == 0) ? 2'h3 : 2'h0);
      apb(0, `UTCF_OFF_LINE_CONTROL, 32'h0);
      chk("line_control", rd, 32'h4 | i);
    end
    apb(1, `UTCF_OFF_LINE_CONTROL, 32'h28);
    chk("parity_on", parity_on, 1'b1);
    chk("mark", tx_parity_bit, 1'b1);
    apb(1, `UTCF_OFF_LINE_CONTROL, 32'h38);
    chk("space", tx_parity_bit, 1'b0);
    apb(0, 12'h0fc, 32'h0);
    chk("unmapped", err, 1'b1);
  endtask
  task automatic t_tables();
    apb(1, `UTCF_OFF_FEATURE_CONTROL, 32'h10);
    apb(1, `UTCF_OFF_FIFO_CONTROL, 32'hf1);
    chk("rx_locked", rx_trigger, 7'h1c);
    chk("tx_locked", tx_trigger, 7'h10);
    apb(1, `UTCF_OFF_ENHANCED_FUNC, 32'h10);
    for (int t = 0; t < 3; t++) for (int s = 0; s < 4; s++) begin
      apb(1, `UTCF_OFF_FEATURE_CONTROL, t << 4);
      apb(1, `UTCF_OFF_FIFO_CONTROL, (s << 6) | (s << 4) | 1);
      chk("rx_trigger", rx_trigger, rxl[4 * t + s]);
      chk("tx_trigger", tx_trigger, txl[4 * t + s]);
    end
    apb(1, `UTCF_OFF_FEATURE_CONTROL, 32'h10);
    chk("rx_table", rx_trigger, 7'h1c);
    chk("tx_table", tx_trigger, 7'h1e);
    // Enable low: the select bits in the same write must not land
    apb(1, `UTCF_OFF_FIFO_CONTROL, 32'h40);
    chk("fifo_enable", fifo_enable, 1'b0);
    chk("rx_kept", rx_trigger, 7'h1c);
  endtask
  task automatic t_prog();
    apb(1, `UTCF_OFF_FEATURE_CONTROL, 32'h30);
    apb(1, `UTCF_OFF_TRIGGER_LEVEL, 32'h14);
    apb(1, `UTCF_OFF_FEATURE_CONTROL, 32'hb0);
    apb(1, `UTCF_OFF_TRIGGER_LEVEL, 32'h28);
    chk("rx_prog", rx_trigger, 7'h14);
    chk("tx_prog", tx_trigger, 7'h28);
  endtask
  task automatic t_irq();
    apb(1, `UTCF_OFF_IRQ_MASK, 32'h7);
    far_u.set_counts(7'h00, 7'h13);
    apb(1, `UTCF_OFF_IRQ_STATUS, 32'h7);
    chk("irq_idle", irq, 1'b0);
    far_u.set_counts(7'h29, 7'h14);
    chk("irq_rx", irq, 1'b1);
    apb(1, `UTCF_OFF_IRQ_STATUS, 32'h2);
    far_u.set_counts(7'h27, 7'h14);
    apb(0, `UTCF_OFF_IRQ_STATUS, 32'h0);
    chk("tx_below", rd, 32'h1);
    // Empty out, then reload only below the level so the empty event is due
    far_u.set_counts(7'h00, 7'h14);
    far_u.set_counts(7'h05, 7'h14);
    apb(1, `UTCF_OFF_IRQ_MASK, 32'h0);
    apb(1, `UTCF_OFF_IRQ_STATUS, 32'h7);
    far_u.set_counts(7'h00, 7'h14);
    apb(0, `UTCF_OFF_IRQ_STATUS, 32'h0);
    chk("tx_empty", rd, 32'h1);
    chk("irq_masked", irq, 1'b0);
  endtask
  task automatic t_parity();
    logic [7:0] lc [6] = '{8'h1b, 8'h1b, 8'h0b, 8'h2b, 8'h3b, 8'h03};
    logic pb [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    logic [2:0] ex [6] = '{3'h4, 3'h0, 3'h0, 3'h4, 3'h4, 3'h0};
    for (int i = 0; i < 6; i++) begin
      apb(1, `UTCF_OFF_IRQ_STATUS, 32'h7);
      apb(1, `UTCF_OFF_LINE_CONTROL, lc[i]);
      far_u.send_char(8'h03, pb[i]);
      apb(0, `UTCF_OFF_IRQ_STATUS, 32'h0);
      chk("parity_status", rd, ex[i]);
    end
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("rst_word", word_bits, 4'h5);
    chk("rst_stop", stop_halves, 2'h2);
    chk("rst_tx", tx_trigger, 7'h01);
    chk("rst_rx", rx_trigger, 7'h01);
    t_format();
    t_tables();
    t_prog();
    t_irq();
    t_parity();
    conclude();
  end
endmodule // uart_trigger_and_char_format_tb
bind utcf_top utcf_props #(.CW(CW)) chk_u (.*);
`default_nettype wire
